// *** verilog/supply_monitor_error_logic.sv ***
// supply supervision, error output, converter driver and channel filters
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps

// How it works
// - apart from a clear to low, each filter output changes only after the sample held the new level for n scans
// - during lockout the error, config and irq registers reset and filters clear; transfer and supply flags set, error low
// - after lockout release the interface select and serial mode pins are captured
// - both supply comparators must hold for four scan periods before acting
// - qualified undervoltage sets its flag in the global error register; operation continues
// - qualified missing voltage sets its flag; host side logic keeps running
// - with converter enable high both supply detections are ignored
// - switches stay off while overcurrent is present, resume automatically after
// - host reads both error registers after power-up; reads update flags, error releases once persistent error is clear
// - switches run from the scan clock; divider bit halves switching frequency
// - converter timing is derived from the internal scan clock
// - drivers stop at shutdown temperature and restart only at restart level
// - the scan clock drives sampling and all averaging filters
// - transfer and supply monitoring are reported on the error output
// - four bad transfers set persistent error and clear filters; four good clear it
// - error output ors persistent error and transfer error flags with supply or converter status, active low
module supply_monitor_error_logic #(
	parameter int unsigned CH = supply_monitor_pkg::CHANNELS
) (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// supply supervision pins
	input  wire logic          lockout_reset,
	input  wire logic          undervolt_cmp,
	input  wire logic          missing_cmp,
	// configuration pins
	input  wire logic          interface_sel,
	input  wire logic          serial_mode_sel0,
	input  wire logic          serial_mode_sel1,
	input  wire logic          converter_enable_in,
	// converter protection pins
	input  wire logic          overcurrent_in,
	input  wire logic          overtemp_shutdown,
	input  wire logic          overtemp_restart_ok,
	// barrier transfer status
	input  wire logic          xfer_toggle,
	input  wire logic          single_xfer_error,
	// channel comparators
	input  wire logic [CH-1:0] chan_cmp,
	// open-drain outputs, enable low while pulling low
	output logic               err_out,
	output logic               err_oe_n,
	output logic               converter_switch_a,
	output logic               converter_switch_a_oe_n,
	output logic               converter_switch_b,
	output logic               converter_switch_b_oe_n,
	// interrupt
	output logic               irq
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int unsigned NSYNC = CH + 12;
	// lockout reads active until the pins have passed both flops, so straps are taken settled
	localparam logic [NSYNC-1:0] SYNC_RST = {{CH{1'b0}}, 12'h800};
	wire [NSYNC-1:0] async_in = {chan_cmp, lockout_reset, undervolt_cmp, missing_cmp, interface_sel,
		serial_mode_sel0, serial_mode_sel1, converter_enable_in, overcurrent_in, overtemp_shutdown,
		overtemp_restart_ok, xfer_toggle, single_xfer_error};

	logic [NSYNC-1:0] meta_ff;
	logic [NSYNC-1:0] sync_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= SYNC_RST;
			sync_ff <= SYNC_RST;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	wire [CH-1:0] s_chan      = sync_ff[NSYNC-1:12];
	wire          s_lockout   = sync_ff[11];
	wire          s_uv        = sync_ff[10];
	wire          s_mv        = sync_ff[9];
	wire          s_ifsel     = sync_ff[8];
	wire          s_mode0     = sync_ff[7];
	wire          s_mode1     = sync_ff[6];
	wire          s_self_pwr  = sync_ff[5];
	wire          s_overcur   = sync_ff[4];
	wire          s_hot       = sync_ff[3];
	wire          s_cool      = sync_ff[2];
	wire          s_xfer_tgl  = sync_ff[1];
	wire          s_xfer_bad  = sync_ff[0];

	// ----------------------------------------
	// scan clock tick
	// ----------------------------------------
	logic [7:0] scan_cnt_ff;
	logic       scan_tick_ff;

	wire scan_wrap = scan_cnt_ff == 8'(supply_monitor_pkg::SCAN_DIV - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_cnt_ff  <= 8'h00;
			scan_tick_ff <= 1'b0;
		end else begin
			scan_cnt_ff  <= scan_wrap ? 8'h00 : scan_cnt_ff + 8'h01;
			scan_tick_ff <= scan_wrap;
		end
	end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire       apb_done   = psel && penable && pready;
	wire       apb_wr     = apb_done && pwrite;
	wire       apb_rd     = apb_done && !pwrite;
	wire       hit_ge     = paddr == supply_monitor_pkg::ADDR_GLOBAL_ERROR;
	wire       hit_ie     = paddr == supply_monitor_pkg::ADDR_INTERNAL_ERROR;
	wire       hit_gc     = paddr == supply_monitor_pkg::ADDR_GLOBAL_CONFIG;
	wire       hit_is     = paddr == supply_monitor_pkg::ADDR_IRQ_STATUS;
	wire       hit_ic     = paddr == supply_monitor_pkg::ADDR_IRQ_CLEAR;
	wire       hit_en     = paddr == supply_monitor_pkg::ADDR_IRQ_ENABLE;
	wire       hit_cs     = paddr == supply_monitor_pkg::ADDR_CHAN_STATUS;
	wire       mapped     = hit_ge | hit_ie | hit_gc | hit_is | hit_ic | hit_en | hit_cs;
	wire       rd_ge      = apb_rd && hit_ge;
	wire       rd_ie      = apb_rd && hit_ie;

	// ----------------------------------------
	// supply comparator blanking
	// ----------------------------------------
	logic [2:0] uv_blank_ff;
	logic [2:0] mv_blank_ff;

	wire uv_raw = s_uv && !s_self_pwr;
	wire mv_raw = s_mv && !s_self_pwr;
	wire uv_ok  = uv_blank_ff == 3'(supply_monitor_pkg::BLANK_TICKS);
	wire mv_ok  = mv_blank_ff == 3'(supply_monitor_pkg::BLANK_TICKS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_blank_ff <= 3'h0;
			mv_blank_ff <= 3'h0;
		end else begin
			uv_blank_ff <= !uv_raw ? 3'h0 : (scan_tick_ff && !uv_ok) ? uv_blank_ff + 3'h1 : uv_blank_ff;
			mv_blank_ff <= !mv_raw ? 3'h0 : (scan_tick_ff && !mv_ok) ? mv_blank_ff + 3'h1 : mv_blank_ff;
		end
	end

	// ----------------------------------------
	// barrier transfer monitor
	// ----------------------------------------
	logic       xfer_tgl_ff;
	logic [2:0] bad_run_ff;
	logic [2:0] good_run_ff;
	logic       persist_ff;

	wire       xfer_evt    = s_xfer_tgl != xfer_tgl_ff;
	wire [2:0] nxt_bad_run = s_xfer_bad ? ((bad_run_ff == 3'(supply_monitor_pkg::XFER_RUN)) ? bad_run_ff :
		bad_run_ff + 3'h1) : 3'h0;
	wire [2:0] nxt_good_run = !s_xfer_bad ? ((good_run_ff == 3'(supply_monitor_pkg::XFER_RUN)) ? good_run_ff :
		good_run_ff + 3'h1) : 3'h0;
	wire       persist_set = xfer_evt && nxt_bad_run == 3'(supply_monitor_pkg::XFER_RUN);
	wire       persist_clr = xfer_evt && nxt_good_run == 3'(supply_monitor_pkg::XFER_RUN);

	// ----------------------------------------
	// converter driver
	// ----------------------------------------
	logic gc_div2_ff;
	logic div_ph_ff;
	logic sw_phase_ff;
	logic hot_off_ff;

	wire nxt_hot_off = s_hot ? 1'b1 : s_cool ? 1'b0 : hot_off_ff;
	wire sw_step     = scan_tick_ff && (!gc_div2_ff || div_ph_ff);
	wire drive_on    = s_self_pwr && !s_overcur && !hot_off_ff;
	wire conv_fault  = s_self_pwr && (s_overcur || hot_off_ff);

	// ----------------------------------------
	// flags and registers
	// ----------------------------------------
	logic                                           ge_uv_ff;
	logic                                           ge_mv_ff;
	logic                                           ie_xfer_ff;
	logic                                           ie_four_ff;
	logic                                           ie_conv_ff;
	logic [supply_monitor_pkg::GC_FILT_W-1:0]       gc_filt_ff;
	logic [supply_monitor_pkg::IRQ_W-1:0]           irq_stat_ff;
	logic [supply_monitor_pkg::IRQ_W-1:0]           irq_en_ff;
	logic                                           lock_d_ff;
	logic                                           strap_ifsel_ff;
	logic                                           strap_mode0_ff;
	logic                                           strap_mode1_ff;

	// undervoltage sets, read clears; set wins
	wire nxt_ge_uv   = (ge_uv_ff && !rd_ge) || uv_ok;
	wire nxt_ge_mv   = (ge_mv_ff && !rd_ge) || mv_ok;
	wire nxt_ie_xfer = (ie_xfer_ff && !rd_ie) || (xfer_evt && s_xfer_bad);
	wire nxt_ie_four = (ie_four_ff && !rd_ie) || persist_ff;
	wire nxt_ie_conv = (ie_conv_ff && !rd_ie) || conv_fault;

	wire [supply_monitor_pkg::IRQ_W-1:0] irq_evt = {conv_fault && !ie_conv_ff, persist_set && !persist_ff,
		mv_ok && !ge_mv_ff, uv_ok && !ge_uv_ff};
	wire [supply_monitor_pkg::IRQ_W-1:0] irq_clr = (apb_wr && hit_ic) ?
		pwdata[supply_monitor_pkg::IRQ_W-1:0] : '0;

	wire supply_err  = s_self_pwr ? (ie_conv_ff || conv_fault) : (ge_uv_ff || ge_mv_ff || uv_ok || mv_ok);
	wire nxt_err     = persist_ff || ie_four_ff || ie_xfer_ff || supply_err;

	wire strap_take  = lock_d_ff && !s_lockout;

	// ----------------------------------------
	// filter bank
	// ----------------------------------------
	filter_if #(.CH(CH)) fbus ();

	// filters run on the scan tick
	assign fbus.scan_tick = scan_tick_ff;
	assign fbus.clear     = persist_ff || s_lockout;
	assign fbus.len_code  = gc_filt_ff;
	assign fbus.sample    = s_chan;

	channel_filter_bank #(.CH(CH)) u_filters (
		.pclk    (pclk),
		.presetn (presetn),
		.fb      (fbus.filt)
	);

	// ----------------------------------------
	// read data mux
	// ----------------------------------------
	wire [31:0] rd_word =
		hit_ge ? {30'h0, ge_mv_ff, ge_uv_ff} :
		hit_ie ? {29'h0, ie_conv_ff, ie_four_ff, ie_xfer_ff} :
		hit_gc ? {28'h0, gc_filt_ff, gc_div2_ff} :
		hit_is ? {28'h0, irq_stat_ff} :
		hit_en ? {28'h0, irq_en_ff} :
		hit_cs ? {21'h0, strap_mode1_ff, strap_mode0_ff, strap_ifsel_ff, 8'(fbus.level)} :
		32'h0;

	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			prdata  <= (psel && penable && !pready && !pwrite) ? rd_word : 32'h0;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// ----------------------------------------
	// lockout-reset state
	// ----------------------------------------
	// lockout is a synchronous register reset, so a field dip restores the reset values of the error, config, irq and transfer monitor registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ge_uv_ff    <= supply_monitor_pkg::GLOBAL_ERROR_RST[supply_monitor_pkg::GE_UNDERVOLT];
			ge_mv_ff    <= supply_monitor_pkg::GLOBAL_ERROR_RST[supply_monitor_pkg::GE_MISSING];
			ie_xfer_ff  <= supply_monitor_pkg::INTERNAL_ERROR_RST[supply_monitor_pkg::IE_XFER];
			ie_four_ff  <= supply_monitor_pkg::INTERNAL_ERROR_RST[supply_monitor_pkg::IE_FOURFOLD];
			ie_conv_ff  <= supply_monitor_pkg::INTERNAL_ERROR_RST[supply_monitor_pkg::IE_CONV_FAULT];
			gc_div2_ff  <= supply_monitor_pkg::GLOBAL_CONFIG_RST[supply_monitor_pkg::GC_DIV2];
			gc_filt_ff  <= supply_monitor_pkg::GLOBAL_CONFIG_RST[3:1];
			irq_en_ff   <= supply_monitor_pkg::IRQ_ENABLE_RST;
			irq_stat_ff <= '0;
			persist_ff  <= 1'b1;
			bad_run_ff  <= 3'h0;
			good_run_ff <= 3'h0;
		end else if (s_lockout) begin
			ge_uv_ff    <= supply_monitor_pkg::GLOBAL_ERROR_RST[supply_monitor_pkg::GE_UNDERVOLT];
			ge_mv_ff    <= supply_monitor_pkg::GLOBAL_ERROR_RST[supply_monitor_pkg::GE_MISSING];
			ie_xfer_ff  <= supply_monitor_pkg::INTERNAL_ERROR_RST[supply_monitor_pkg::IE_XFER];
			ie_four_ff  <= supply_monitor_pkg::INTERNAL_ERROR_RST[supply_monitor_pkg::IE_FOURFOLD];
			ie_conv_ff  <= supply_monitor_pkg::INTERNAL_ERROR_RST[supply_monitor_pkg::IE_CONV_FAULT];
			gc_div2_ff  <= supply_monitor_pkg::GLOBAL_CONFIG_RST[supply_monitor_pkg::GC_DIV2];
			gc_filt_ff  <= supply_monitor_pkg::GLOBAL_CONFIG_RST[3:1];
			irq_en_ff   <= supply_monitor_pkg::IRQ_ENABLE_RST;
			irq_stat_ff <= '0;
			persist_ff  <= 1'b1;
			bad_run_ff  <= 3'h0;
			good_run_ff <= 3'h0;
		end else begin
			ge_uv_ff    <= nxt_ge_uv;
			ge_mv_ff    <= nxt_ge_mv;
			ie_xfer_ff  <= nxt_ie_xfer;
			ie_four_ff  <= nxt_ie_four;
			ie_conv_ff  <= nxt_ie_conv;
			gc_div2_ff  <= (apb_wr && hit_gc) ? pwdata[supply_monitor_pkg::GC_DIV2] : gc_div2_ff;
			gc_filt_ff  <= (apb_wr && hit_gc) ? pwdata[3:1] : gc_filt_ff;
			irq_en_ff   <= (apb_wr && hit_en) ? pwdata[supply_monitor_pkg::IRQ_W-1:0] : irq_en_ff;
			// sticky events, a new event beats a clear in the same cycle
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
			persist_ff  <= persist_set ? 1'b1 : persist_clr ? 1'b0 : persist_ff;
			bad_run_ff  <= xfer_evt ? nxt_bad_run : bad_run_ff;
			good_run_ff <= xfer_evt ? nxt_good_run : good_run_ff;
		end
	end

	// ----------------------------------------
	// straps, transfer edge, converter state
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_d_ff      <= 1'b1;
			strap_ifsel_ff <= 1'b1;
			strap_mode0_ff <= 1'b0;
			strap_mode1_ff <= 1'b0;
			xfer_tgl_ff    <= 1'b0;
			hot_off_ff     <= 1'b0;
			div_ph_ff      <= 1'b0;
			sw_phase_ff    <= 1'b0;
		end else begin
			lock_d_ff      <= s_lockout;
			strap_ifsel_ff <= strap_take ? s_ifsel : strap_ifsel_ff;
			strap_mode0_ff <= strap_take ? s_mode0 : strap_mode0_ff;
			strap_mode1_ff <= strap_take ? s_mode1 : strap_mode1_ff;
			xfer_tgl_ff    <= s_xfer_tgl;
			hot_off_ff     <= nxt_hot_off;
			div_ph_ff      <= scan_tick_ff ? !div_ph_ff : div_ph_ff;
			sw_phase_ff    <= sw_step ? !sw_phase_ff : sw_phase_ff;
		end
	end

	// ----------------------------------------
	// output stage
	// ----------------------------------------
	// the pins stay released while the driver is off, so the transformer never sees dc
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_out                 <= 1'b0;
			err_oe_n                <= 1'b0;
			converter_switch_a      <= 1'b0;
			converter_switch_a_oe_n <= 1'b1;
			converter_switch_b      <= 1'b0;
			converter_switch_b_oe_n <= 1'b1;
			irq                     <= 1'b0;
		end else begin
			err_out                 <= 1'b0;
			err_oe_n                <= !nxt_err;
			converter_switch_a      <= 1'b0;
			converter_switch_a_oe_n <= !(drive_on && !sw_phase_ff);
			converter_switch_b      <= 1'b0;
			converter_switch_b_oe_n <= !(drive_on && sw_phase_ff);
			irq                     <= |(irq_stat_ff & irq_en_ff);
		end
	end

endmodule

// *** verilog/supply_monitor_pkg.sv ***
// constants, register map and field layout of the supply monitor and error logic
package supply_monitor_pkg;

	// ----------------------------------------
	// clocking and timing
	// ----------------------------------------
	localparam int unsigned PCLK_HZ      = 125_000_000;
	localparam int unsigned SCAN_HZ      = 500_000;
	localparam int unsigned SCAN_DIV     = PCLK_HZ / SCAN_HZ;
	localparam int unsigned BLANK_NS     = 8_000;
	localparam int unsigned BLANK_TICKS  = (BLANK_NS * (SCAN_HZ / 1000) + 999_999) / 1_000_000;
	localparam int unsigned XFER_RUN     = 4;
	localparam int unsigned CHANNELS     = 8;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_GLOBAL_ERROR   = 8'h00;
	localparam logic [7:0] ADDR_INTERNAL_ERROR = 8'h04;
	localparam logic [7:0] ADDR_GLOBAL_CONFIG  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_CLEAR      = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h14;
	localparam logic [7:0] ADDR_CHAN_STATUS    = 8'h18;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned GE_UNDERVOLT   = 0;
	localparam int unsigned GE_MISSING     = 1;
	localparam int unsigned IE_XFER        = 0;
	localparam int unsigned IE_FOURFOLD    = 1;
	localparam int unsigned IE_CONV_FAULT  = 2;
	localparam int unsigned GC_DIV2        = 0;
	localparam int unsigned GC_FILT_LSB    = 1;
	localparam int unsigned GC_FILT_W      = 3;
	localparam int unsigned IRQ_UNDERVOLT  = 0;
	localparam int unsigned IRQ_MISSING    = 1;
	localparam int unsigned IRQ_PERSIST    = 2;
	localparam int unsigned IRQ_CONV_FAULT = 3;
	localparam int unsigned IRQ_W          = 4;
	localparam int unsigned CS_DATA_LSB    = 0;
	localparam int unsigned CS_IFSEL       = 8;
	localparam int unsigned CS_MODE0       = 9;
	localparam int unsigned CS_MODE1       = 10;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [1:0] GLOBAL_ERROR_RST   = 2'h3;
	localparam logic [2:0] INTERNAL_ERROR_RST = 3'h3;
	localparam logic [3:0] GLOBAL_CONFIG_RST  = 4'h0;
	localparam logic [3:0] IRQ_ENABLE_RST     = 4'h0;

endpackage

// *** verilog/filter_if.sv ***
// signals shared between the top and the channel filter bank
`timescale 1ns/1ps
interface filter_if #(
	parameter int unsigned CH = 8
);
	logic          scan_tick;
	logic          clear;
	logic [2:0]    len_code;
	logic [CH-1:0] sample;
	logic [CH-1:0] level;

	modport ctrl (
		output scan_tick, clear, len_code, sample,
		input  level
	);
	modport filt (
		input  scan_tick, clear, len_code, sample,
		output level
	);
endinterface

// *** verilog/channel_filter_bank.sv ***
// per-channel averaging filters clocked by the scan tick
`timescale 1ns/1ps
module channel_filter_bank #(
	parameter int unsigned CH = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// filter control and data
	filter_if.filt   fb
);

	// averaging length in scan samples for a config code
	function automatic logic [7:0] avg_len(input logic [2:0] code);
		avg_len = 8'h01 << code;
	endfunction

	wire [7:0] len = avg_len(fb.len_code);

	logic [CH-1:0] level_ff;
	logic [7:0]    cnt_ff [CH];

	assign fb.level = level_ff;

	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : g_ch
			wire       differs   = fb.sample[g] != level_ff[g];
			wire [7:0] nxt_cnt   = differs ? cnt_ff[g] + 8'h01 : 8'h00;
			wire       nxt_flip  = differs && (nxt_cnt >= len);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					level_ff[g] <= 1'b0;
					cnt_ff[g]   <= 8'h00;
				end else if (fb.clear) begin
					level_ff[g] <= 1'b0;
					cnt_ff[g]   <= 8'h00;
				end else if (fb.scan_tick) begin
					level_ff[g] <= nxt_flip ? fb.sample[g] : level_ff[g];
					cnt_ff[g]   <= nxt_flip ? 8'h00 : nxt_cnt;
				end
			end
		end
	endgenerate

endmodule

// *** verif/supply_monitor_error_logic_sva.sv ***
// checker for the supply monitor and error logic ports
`timescale 1ns/1ps
module supply_monitor_error_logic_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        lockout_reset,
	input wire logic        undervolt_cmp,
	input wire logic        converter_enable_in,
	input wire logic        overcurrent_in,
	input wire logic        err_oe_n,
	input wire logic        converter_switch_a_oe_n,
	input wire logic        converter_switch_b_oe_n,
	input wire logic        irq
);
	// margin covers blanking, tick phase and pin flops
	localparam int UV_LATE = 1400;
	logic [10:0] uv_cnt_ff;
	logic [10:0] nxt_uv_cnt;
	assign nxt_uv_cnt = (undervolt_cmp && !converter_enable_in && !lockout_reset)
		? ((uv_cnt_ff == 11'h7ff) ? uv_cnt_ff : uv_cnt_ff + 11'h001) : 11'h000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) uv_cnt_ff <= 11'h000;
		else uv_cnt_ff <= nxt_uv_cnt;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence access_wait;
		psel && penable && !pready;
	endsequence
	// two pin flops, the register reset and the output flop lie between pin and outputs
	sequence lockout_held;
		lockout_reset [*5];
	endsequence
	sequence overload_held;
		overcurrent_in [*4];
	endsequence
	sequence switches_off;
		converter_switch_a_oe_n && converter_switch_b_oe_n;
	endsequence
	chk_apb_answer: assert property (access_wait |=> pready) else $error("no answer after access");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	chk_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without request");
	chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read data");
	chk_lockout_state: assert property (lockout_held |-> !err_oe_n && !irq
		&& converter_switch_a_oe_n && converter_switch_b_oe_n) else $error("lockout state wrong");
	chk_overload_off: assert property (overload_held |-> switches_off)
		else $error("switch on in overload");
	chk_switch_apart: assert property (converter_switch_a_oe_n || converter_switch_b_oe_n)
		else $error("both switches on");
	chk_undervolt_err: assert property (uv_cnt_ff >= UV_LATE |-> !err_oe_n)
		else $error("undervolt not reported");
endmodule
bind supply_monitor_error_logic supply_monitor_error_logic_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.lockout_reset(lockout_reset), .undervolt_cmp(undervolt_cmp), .converter_enable_in(converter_enable_in),
	.overcurrent_in(overcurrent_in), .err_oe_n(err_oe_n), .converter_switch_a_oe_n(converter_switch_a_oe_n),
	.converter_switch_b_oe_n(converter_switch_b_oe_n), .irq(irq));

// *** verif/apb_host_model.sv ***
// host controller model speaking apb to the device
`timescale 1ns/1ps
module apb_host_model (
	// clock
	input wire logic         pclk,
	// apb
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// host runs one read or write transfer to any address and waits for pready
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the supply monitor and error logic
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0, presetn = 1'b0, lockout_reset = 1'b0, undervolt_cmp = 1'b0, missing_cmp = 1'b0;
	logic conv_en = 1'b0, overcurrent_in = 1'b0, xfer_toggle = 1'b0, bad = 1'b0, hot = 1'b0, cool = 1'b1, s0;
	logic psel, penable, pwrite, pready, pslverr, err_out, err_oe_n, sa, sa_oe_n, sb, sb_oe_n, irq, e;
	logic [7:0] paddr, chan = 8'h00;
	logic [31:0] pwdata, prdata, r;
	int fail_count = 0, samples_checked = 0, cycles = 0;
	typedef struct { logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic ex; } row_t;
	row_t rows[8] = '{'{8'h00,0,0,32'h3,0}, '{8'h04,0,0,32'h3,0}, '{8'h08,0,0,32'h0,0}, '{8'h14,0,0,32'h0,0},
		'{8'h08,1,32'h1,32'h1,0}, '{8'h14,1,32'hf,32'hf,0}, '{8'h18,0,0,32'h300,0}, '{8'h1c,0,0,32'h0,1}};
	always #4 pclk = ~pclk;
	apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	supply_monitor_error_logic DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lockout_reset(lockout_reset), .undervolt_cmp(undervolt_cmp), .missing_cmp(missing_cmp),
		.interface_sel(1'b1), .serial_mode_sel0(1'b1), .serial_mode_sel1(1'b0), .converter_enable_in(conv_en),
		.overcurrent_in(overcurrent_in), .overtemp_shutdown(hot), .overtemp_restart_ok(cool),
		.xfer_toggle(xfer_toggle), .single_xfer_error(bad), .chan_cmp(chan), .err_out(err_out),
		.err_oe_n(err_oe_n), .converter_switch_a(sa), .converter_switch_a_oe_n(sa_oe_n), .converter_switch_b(sb),
		.converter_switch_b_oe_n(sb_oe_n), .irq(irq));
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic xfers(input logic b);
		repeat (4) begin
			repeat (10) @(posedge pclk);
			bad <= b;
			xfer_toggle <= ~xfer_toggle;
		end
		repeat (20) @(posedge pclk);
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge pclk);
		undervolt_cmp <= 1'b0;
		repeat (300) @(posedge pclk);
	endtask
	task automatic conv_state(input string n, input logic oc, input logic h, input logic c, input logic on);
		overcurrent_in <= oc;
		hot <= h;
		cool <= c;
		repeat (10) @(posedge pclk);
		check(n, {30'h0, sa_oe_n & sb_oe_n, sa_oe_n ^ sb_oe_n}, on ? 32'h1 : 32'h2);
	endtask
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		xfers(1'b0);
		foreach (rows[i]) begin
			host.xfer(rows[i].a, rows[i].w, rows[i].d, r, e);
			check("slverr", {31'h0, e}, {31'h0, rows[i].ex});
			if (rows[i].w) host.xfer(rows[i].a, 1'b0, 32'h0, r, e);
			check("reg", r, rows[i].x);
		end
		host.xfer(8'h08, 1, 32'h4, r, e);
		chan <= 8'h01;
		repeat (600) @(posedge pclk);
		host.xfer(8'h18, 0, 0, r, e);
		check("filt_hold", r, 32'h300);
		repeat (1000) @(posedge pclk);
		host.xfer(8'h18, 0, 0, r, e);
		check("filt_flip", r, 32'h301);
		host.xfer(8'h00, 0, 0, r, e);
		host.xfer(8'h04, 0, 0, r, e);
		check("intern", r, 32'h0);
		check("err", {31'h0, err_oe_n}, 32'h1);
		undervolt_cmp <= 1'b1;
		hold(500);
		host.xfer(8'h00, 0, 0, r, e);
		check("glitch", r, 32'h0);
		undervolt_cmp <= 1'b1;
		repeat (2000) @(posedge pclk);
		check("irq", {31'h0, irq}, 32'h1);
		host.xfer(8'h00, 0, 0, r, e);
		check("uv", r, 32'h1);
		hold(0);
		host.xfer(8'h00, 0, 0, r, e);
		host.xfer(8'h10, 1, 32'hf, r, e);
		repeat (2) @(posedge pclk);
		check("irqclr", {31'h0, irq}, 32'h0);
		conv_en <= 1'b1;
		undervolt_cmp <= 1'b1;
		overcurrent_in <= 1'b1;
		hold(2000);
		host.xfer(8'h00, 0, 0, r, e);
		check("self", r, 32'h0);
		conv_state("run", 1'b0, 1'b0, 1'b1, 1'b1);
		check("od_low", {29'h0, err_out, sa, sb}, 32'h0);
		s0 = sa_oe_n;
		repeat (250) @(posedge pclk);
		check("sw_step", {31'h0, sa_oe_n}, {31'h0, ~s0});
		host.xfer(8'h08, 1, 32'h1, r, e);
		repeat (2) @(posedge pclk);
		s0 = sa_oe_n;
		repeat (500) @(posedge pclk);
		check("sw_div2", {31'h0, sa_oe_n}, {31'h0, ~s0});
		conv_state("overload", 1'b1, 1'b0, 1'b1, 1'b0);
		conv_state("hot", 1'b0, 1'b1, 1'b0, 1'b0);
		conv_state("hyst", 1'b0, 1'b0, 1'b0, 1'b0);
		conv_state("restart", 1'b0, 1'b0, 1'b1, 1'b1);
		conv_en <= 1'b0;
		xfers(1'b1);
		host.xfer(8'h04, 0, 0, r, e);
		check("persist", r & 32'h3, 32'h3);
		check("errbad", {31'h0, err_oe_n}, 32'h0);
		lockout_reset <= 1'b1;
		repeat (6) @(posedge pclk);
		lockout_reset <= 1'b0;
		repeat (4) @(posedge pclk);
		host.xfer(8'h08, 0, 0, r, e);
		check("lockout", r, 32'h0);
		report_and_stop();
	end
endmodule
